// File: hdl/lcrb_bank.sv
// Purpose : control register bank of the lighting management unit
// Assumes : the serial front end delivers decoded byte reads and writes
// Notes   : controls are registered, so they follow a write by two cycles

module lcrb_bank #(
  parameter int FADE_SHORT_CYCLES = lcrb_pkg::FADE_SHORT_CYC,
  parameter int FADE_LONG_CYCLES  = lcrb_pkg::FADE_LONG_CYC
) (
  input  wire logic              clock_in,        // device clock, 125 MHz
  input  wire logic              rstn_in,         // power-on reset, active low
  input  wire logic              reg_wr_in,       // write strobe, one cycle
  input  wire logic              reg_rd_in,       // read strobe, one cycle
  input  wire logic [7:0]        reg_addr_in,     // register address
  input  wire logic [7:0]        reg_wdata_in,    // write data
  output logic      [7:0]        reg_rdata_out,   // read data, held
  output logic                   reg_rvalid_out,  // read data valid, one cycle
  input  wire logic              ext_pwm_in,      // external PWM dimming input
  output lcrb_pkg::lcrb_ctrl_t   ctrl_out,        // decoded controls
  output logic      [27:0]       fade_cycles_out  // full-scale fade time in cycles
);

  // ----------------------------------------------------------------------
  // address decode and register storage
  // ----------------------------------------------------------------------
  logic [lcrb_pkg::NUM_REGS-1:0] hit;
  logic [7:0]                    q [lcrb_pkg::NUM_REGS];

  genvar gi;
  generate
    for (gi = 0; gi < lcrb_pkg::NUM_REGS; gi++) begin : g_reg
      assign hit[gi] = (reg_addr_in == lcrb_pkg::REG_OFS[gi]);
      lcrb_reg8 #(
        .RESET_VAL (lcrb_pkg::REG_RST[gi]),
        .RW_MASK   (lcrb_pkg::REG_RW[gi])
      ) u_reg (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .wr_in    (reg_wr_in && hit[gi]),
        .wdata_in (reg_wdata_in),
        .q_out    (q[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;
  logic       rvalid_reg;

  always_comb begin
    rdata_next = 8'h00;
    for (int i = 0; i < lcrb_pkg::NUM_REGS; i++) begin
      if (hit[i]) begin
        rdata_next = q[i];
      end
    end
  end

  // a read in the same cycle as a write to that register returns the old value
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd_in;
    end
  end

  assign reg_rdata_out  = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;

  // ----------------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------------
  logic [7:0] kctl;
  logic [7:0] kdim;
  logic [7:0] kcur;
  logic [7:0] bctl;
  logic [7:0] xdim;
  logic [2:0] sink_sel;
  logic [2:0] sink_xen;
  logic [2:0] sink_gate;
  logic       pri_gate;
  logic       sec_gate;
  lcrb_pkg::lcrb_ctrl_t ctrl_next;
  lcrb_pkg::lcrb_ctrl_t ctrl_reg;
  logic [27:0] fade_next;
  logic [27:0] fade_reg;

  assign kctl = q[lcrb_pkg::IDX_KCTL];
  assign kdim = q[lcrb_pkg::IDX_KDIM];
  assign kcur = q[lcrb_pkg::IDX_KCUR];
  assign bctl = q[lcrb_pkg::IDX_BCTL];
  assign xdim = q[lcrb_pkg::IDX_XDIM];

  assign sink_sel = {kctl[lcrb_pkg::B_SINK3_EN], kctl[lcrb_pkg::B_SINK2_EN],
                     kctl[lcrb_pkg::B_SINK1_EN]};
  assign sink_xen = {xdim[lcrb_pkg::B_XSINK3], xdim[lcrb_pkg::B_XSINK2],
                     xdim[lcrb_pkg::B_XSINK1]};

  // a disabled external input leaves the output steady on, not gated off
  assign sink_gate = ~sink_xen | {3{ext_pwm_in}};
  assign pri_gate  = ~xdim[lcrb_pkg::B_XPRI] | ext_pwm_in;
  assign sec_gate  = ~xdim[lcrb_pkg::B_XSEC] | ext_pwm_in;

  always_comb begin
    ctrl_next = '0;
    ctrl_next.keypad_internal_dim_enable = kctl[lcrb_pkg::B_KINT_DIM];
    ctrl_next.keypad_outputs_enable      = kctl[lcrb_pkg::B_KOUT_EN];
    ctrl_next.keypad_drive_style         = kctl[lcrb_pkg::B_KSTYLE];
    // master enable overrides each sink enable
    ctrl_next.keypad_sink_on =
      sink_sel & sink_gate & {3{kctl[lcrb_pkg::B_KOUT_EN]}};
    ctrl_next.keypad_pwm_balance  = kdim[lcrb_pkg::B_BALANCE_LO +: 3];
    ctrl_next.keypad_pwm_level    = kdim[lcrb_pkg::B_LEVEL_LO +: 3];
    ctrl_next.keypad_overlap_mode = kdim[lcrb_pkg::B_OVERLAP];
    ctrl_next.sink1_max_scale     = kcur[lcrb_pkg::B_SCALE1_LO +: 2];
    ctrl_next.sink2_max_scale     = kcur[lcrb_pkg::B_SCALE2_LO +: 2];
    ctrl_next.sink3_max_scale     = kcur[lcrb_pkg::B_SCALE3_LO +: 2];
    ctrl_next.fade_duration_select = bctl[lcrb_pkg::B_FADE_DUR];
    ctrl_next.fade_on_primary =
      bctl[lcrb_pkg::B_FADE_EN] & ~bctl[lcrb_pkg::B_FADE_SEL];
    ctrl_next.fade_on_secondary =
      bctl[lcrb_pkg::B_FADE_EN] & bctl[lcrb_pkg::B_FADE_SEL];
    ctrl_next.primary_on   = bctl[lcrb_pkg::B_PRI_EN] & pri_gate;
    ctrl_next.secondary_on = bctl[lcrb_pkg::B_SEC_EN] & sec_gate;
    // codes pass unchanged: the driver scales them at 0.1 mA per step
    ctrl_next.primary_code = q[lcrb_pkg::IDX_PCUR];
    ctrl_next.secondary_code = bctl[lcrb_pkg::B_SHARED] ?
      q[lcrb_pkg::IDX_PCUR] : q[lcrb_pkg::IDX_SCUR];
    ctrl_next.ext_pwm_pin_enable = q[lcrb_pkg::IDX_GCFG][lcrb_pkg::B_PWM_PIN];
    ctrl_next.gpio_direction = q[lcrb_pkg::IDX_GCFG][2:0];
    ctrl_next.gpio_levels    = q[lcrb_pkg::IDX_GLVL][2:0];
    ctrl_next.active_not_standby = q[lcrb_pkg::IDX_PWR][lcrb_pkg::B_ACTIVE];
    ctrl_next.boost_enable = q[lcrb_pkg::IDX_PWR][lcrb_pkg::B_BOOST_EN];
    ctrl_next.boost_dummy_load_enable =
      q[lcrb_pkg::IDX_PWR][lcrb_pkg::B_DUMMY];
    ctrl_next.boost_voltage = q[lcrb_pkg::IDX_BST];
  end

  always_comb begin
    fade_next = bctl[lcrb_pkg::B_FADE_DUR] ?
      28'(FADE_LONG_CYCLES) : 28'(FADE_SHORT_CYCLES);
  end

  // reset values mirror the bank's own defaults: switch drive, dummy load on
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_reg <= '0;
      ctrl_reg.keypad_drive_style      <= 1'b1;
      ctrl_reg.boost_dummy_load_enable <= 1'b1;
      ctrl_reg.boost_voltage           <= lcrb_pkg::RST_BOOST_VOLTAGE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fade_reg <= 28'(FADE_SHORT_CYCLES);
    end else begin
      fade_reg <= fade_next;
    end
  end

  assign ctrl_out        = ctrl_reg;
  assign fade_cycles_out = fade_reg;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  logic past_valid;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      past_valid <= 1'b0;
    end else begin
      past_valid <= 1'b1;
    end
  end

  a_reset_defaults: assert property (
    !past_valid |->
    (kctl == 8'h20 && q[lcrb_pkg::IDX_PWR] == 8'h04 &&
     q[lcrb_pkg::IDX_BST] == 8'h08 && q[lcrb_pkg::IDX_PCUR] == 8'h00))
    else $error("register not at power-on value");

  a_ctrl_defaults: assert property (
    !past_valid |->
    (ctrl_out.keypad_drive_style && ctrl_out.boost_dummy_load_enable &&
     ctrl_out.boost_voltage == 8'h08 && fade_cycles_out == 28'(FADE_SHORT_CYCLES)))
    else $error("controls not at power-on value");

  // the port leaves one idle edge between a write and the read that checks it
  a_write_readback: assert property (
    (reg_wr_in && reg_addr_in == 8'h04) ##1 !reg_wr_in ##1
    (reg_rd_in && !reg_wr_in && reg_addr_in == 8'h04)
    |=> reg_rvalid_out && reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("primary code readback mismatch");

  a_read_answer: assert property (
    reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");

  a_ro_bits_fixed: assert property (
    kctl[4] == 1'b0 && kctl[0] == 1'b0 && kdim[7] == 1'b0 &&
    bctl[7:6] == 2'b00 && xdim[7:5] == 3'b000 &&
    q[lcrb_pkg::IDX_PWR][7] == 1'b0 && q[lcrb_pkg::IDX_GLVL][7:3] == 5'h00)
    else $error("read-only bit changed");

  a_unmapped_zero: assert property (
    (reg_rd_in && reg_addr_in == 8'h08) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");

  a_unmapped_any: assert property (
    (reg_rd_in && !(|hit)) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read returned data");

  a_unmapped_nowrite: assert property (
    (reg_wr_in && !(|hit)) |=> ($stable(kctl) && $stable(bctl) &&
     $stable(q[lcrb_pkg::IDX_BST]) && $stable(xdim)))
    else $error("unmapped write changed a register");

  a_sink_master: assert property (
    !kctl[lcrb_pkg::B_KOUT_EN] |=> ctrl_out.keypad_sink_on == 3'b000)
    else $error("keypad sink on while master enable off");

  a_sink_follow: assert property (
    (kctl[lcrb_pkg::B_KOUT_EN] && xdim[4:2] == 3'b000)
    |=> ctrl_out.keypad_sink_on == {$past(kctl[1]), $past(kctl[2]),
                                    $past(kctl[3])})
    else $error("sink enable not followed");

  a_ext_dim_route: assert property (
    (xdim[lcrb_pkg::B_XPRI] && bctl[lcrb_pkg::B_PRI_EN])
    |=> ctrl_out.primary_on == $past(ext_pwm_in))
    else $error("external PWM not routed to primary");

  a_bl_enables: assert property (
    (!xdim[lcrb_pkg::B_XPRI] && !xdim[lcrb_pkg::B_XSEC])
    |=> (ctrl_out.primary_on == $past(bctl[1]) &&
         ctrl_out.secondary_on == $past(bctl[0])))
    else $error("backlight enable not followed");

  a_shared_code: assert property (
    bctl[lcrb_pkg::B_SHARED] |=>
    ctrl_out.secondary_code == ctrl_out.primary_code)
    else $error("shared code not applied");

  a_own_code: assert property (
    !bctl[lcrb_pkg::B_SHARED] |=>
    ctrl_out.secondary_code == $past(q[lcrb_pkg::IDX_SCUR]))
    else $error("secondary code not its own");

  a_fade_select: assert property (
    ##1 (ctrl_out.fade_on_primary == ($past(bctl[3]) && !$past(bctl[4])) &&
         ctrl_out.fade_on_secondary == ($past(bctl[3]) && $past(bctl[4]))))
    else $error("fade target wrong");

  a_fade_duration: assert property (
    (reg_wr_in && reg_addr_in == 8'h03 && reg_wdata_in[5])
    |-> ##2 fade_cycles_out == 28'(FADE_LONG_CYCLES))
    else $error("fade duration not long");

  a_fade_short: assert property (
    (reg_wr_in && reg_addr_in == 8'h03 && !reg_wdata_in[5])
    |-> ##2 fade_cycles_out == 28'(FADE_SHORT_CYCLES))
    else $error("fade duration not short");

  a_style_written: assert property (
    (reg_wr_in && reg_addr_in == 8'h00)
    |-> ##2 (ctrl_out.keypad_drive_style == $past(reg_wdata_in[5], 2) &&
             ctrl_out.keypad_internal_dim_enable == $past(reg_wdata_in[7], 2)))
    else $error("keypad control fields not applied");

  a_dim_fields: assert property (
    ##1 (ctrl_out.keypad_pwm_balance == $past(kdim[6:4]) &&
         ctrl_out.keypad_pwm_level == $past(kdim[3:1]) &&
         ctrl_out.keypad_overlap_mode == $past(kdim[0]) &&
         ctrl_out.sink1_max_scale == $past(kcur[5:4])))
    else $error("dimming field mismatch");

  a_scale_fields: assert property (
    ##1 (ctrl_out.sink2_max_scale == $past(kcur[3:2]) &&
         ctrl_out.sink3_max_scale == $past(kcur[1:0])))
    else $error("sink scale mismatch");

  a_code_pass: assert property (
    ##1 (ctrl_out.primary_code == $past(q[lcrb_pkg::IDX_PCUR]) &&
         ctrl_out.boost_voltage == $past(q[lcrb_pkg::IDX_BST])))
    else $error("current or boost code mismatch");

  a_power_bits: assert property (
    ##1 (ctrl_out.boost_enable == $past(q[lcrb_pkg::IDX_PWR][5]) &&
         ctrl_out.gpio_direction == $past(q[lcrb_pkg::IDX_GCFG][2:0])))
    else $error("power or direction bits mismatch");

  a_standby_load: assert property (
    ##1 (ctrl_out.active_not_standby == $past(q[lcrb_pkg::IDX_PWR][6]) &&
         ctrl_out.boost_dummy_load_enable == $past(q[lcrb_pkg::IDX_PWR][2])))
    else $error("standby or dummy load mismatch");

  a_read_pulse: assert property (
    reg_rvalid_out |-> $past(reg_rd_in))
    else $error("read valid without request");

  c_shared_mode: cover property (
    (reg_wr_in && reg_addr_in == 8'h03 && reg_wdata_in[2]) ##2
    ctrl_out.secondary_code == ctrl_out.primary_code);
  c_ext_dim_sink: cover property (
    ctrl_out.keypad_sink_on != 3'b000 && xdim[4:2] != 3'b000);
  c_unmapped_read: cover property (reg_rd_in && !(|hit));
  c_boost_up: cover property (ctrl_out.boost_enable && ctrl_out.active_not_standby);

endmodule : lcrb_bank

// File: hdl/lcrb_pkg.sv
// Purpose : constants and types shared by the lighting control register bank
// Assumes : byte-wide registers at byte offsets, one clock at 125 MHz
// Notes   : register order in the tables below is the bank's index order
package lcrb_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_KEYPAD_CONTROL       = 8'h00;
  localparam logic [7:0] OFS_KEYPAD_DIMMING       = 8'h01;
  localparam logic [7:0] OFS_KEYPAD_CURRENT_LIMIT = 8'h02;
  localparam logic [7:0] OFS_BACKLIGHT_CONTROL    = 8'h03;
  localparam logic [7:0] OFS_PRIMARY_CURRENT      = 8'h04;
  localparam logic [7:0] OFS_SECONDARY_CURRENT    = 8'h05;
  localparam logic [7:0] OFS_GPIO_CONFIG          = 8'h06;
  localparam logic [7:0] OFS_GPIO_LEVELS          = 8'h07;
  localparam logic [7:0] OFS_POWER_ENABLES        = 8'h0B;
  localparam logic [7:0] OFS_BOOST_VOLTAGE        = 8'h0D;
  localparam logic [7:0] OFS_EXTERNAL_DIM_ENABLE  = 8'h2B;

  localparam int NUM_REGS = 11;

  // ----------------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------------
  localparam int IDX_KCTL = 0;
  localparam int IDX_KDIM = 1;
  localparam int IDX_KCUR = 2;
  localparam int IDX_BCTL = 3;
  localparam int IDX_PCUR = 4;
  localparam int IDX_SCUR = 5;
  localparam int IDX_GCFG = 6;
  localparam int IDX_GLVL = 7;
  localparam int IDX_PWR  = 8;
  localparam int IDX_BST  = 9;
  localparam int IDX_XDIM = 10;

  // ----------------------------------------------------------------------
  // power-on values and writable-bit masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_KEYPAD_CONTROL = 8'h20;
  localparam logic [7:0] RST_ZERO           = 8'h00;
  localparam logic [7:0] RST_POWER_ENABLES  = 8'h04;
  localparam logic [7:0] RST_BOOST_VOLTAGE  = 8'h08;

  localparam logic [7:0] RW_KEYPAD_CONTROL  = 8'hEE;
  localparam logic [7:0] RW_KEYPAD_DIMMING  = 8'h7F;
  localparam logic [7:0] RW_LOW6            = 8'h3F;
  localparam logic [7:0] RW_ALL             = 8'hFF;
  localparam logic [7:0] RW_GPIO_CONFIG     = 8'h17;
  localparam logic [7:0] RW_GPIO_LEVELS     = 8'h07;
  localparam logic [7:0] RW_POWER_ENABLES   = 8'h64;
  localparam logic [7:0] RW_EXT_DIM         = 8'h1F;

  localparam logic [7:0] REG_OFS [NUM_REGS] = '{
    OFS_KEYPAD_CONTROL, OFS_KEYPAD_DIMMING, OFS_KEYPAD_CURRENT_LIMIT,
    OFS_BACKLIGHT_CONTROL, OFS_PRIMARY_CURRENT, OFS_SECONDARY_CURRENT,
    OFS_GPIO_CONFIG, OFS_GPIO_LEVELS, OFS_POWER_ENABLES,
    OFS_BOOST_VOLTAGE, OFS_EXTERNAL_DIM_ENABLE};
  localparam logic [7:0] REG_RST [NUM_REGS] = '{
    RST_KEYPAD_CONTROL, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
    RST_ZERO, RST_ZERO, RST_POWER_ENABLES, RST_BOOST_VOLTAGE, RST_ZERO};
  localparam logic [7:0] REG_RW [NUM_REGS] = '{
    RW_KEYPAD_CONTROL, RW_KEYPAD_DIMMING, RW_LOW6, RW_LOW6, RW_ALL, RW_ALL,
    RW_GPIO_CONFIG, RW_GPIO_LEVELS, RW_POWER_ENABLES, RW_ALL, RW_EXT_DIM};

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int B_KINT_DIM   = 7;
  localparam int B_KOUT_EN    = 6;
  localparam int B_KSTYLE     = 5;
  localparam int B_SINK1_EN   = 3;
  localparam int B_SINK2_EN   = 2;
  localparam int B_SINK3_EN   = 1;
  localparam int B_BALANCE_LO = 4;
  localparam int B_LEVEL_LO   = 1;
  localparam int B_OVERLAP    = 0;
  localparam int B_SCALE1_LO  = 4;
  localparam int B_SCALE2_LO  = 2;
  localparam int B_SCALE3_LO  = 0;
  localparam int B_FADE_DUR   = 5;
  localparam int B_FADE_SEL   = 4;
  localparam int B_FADE_EN    = 3;
  localparam int B_SHARED     = 2;
  localparam int B_PRI_EN     = 1;
  localparam int B_SEC_EN     = 0;
  localparam int B_PWM_PIN    = 4;
  localparam int B_ACTIVE     = 6;
  localparam int B_BOOST_EN   = 5;
  localparam int B_DUMMY      = 2;
  localparam int B_XSINK1     = 4;
  localparam int B_XSINK2     = 3;
  localparam int B_XSINK3     = 2;
  localparam int B_XPRI       = 1;
  localparam int B_XSEC       = 0;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ      = 125;
  localparam int FADE_SHORT_MS = 650;
  localparam int FADE_LONG_MS  = 1300;
  localparam int FADE_SHORT_CYC = FADE_SHORT_MS * 1000 * CLK_MHZ;
  localparam int FADE_LONG_CYC  = FADE_LONG_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------------
  // decoded controls handed to the analog and dimming engines
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       keypad_internal_dim_enable;
    logic       keypad_outputs_enable;
    logic       keypad_drive_style;
    logic [2:0] keypad_sink_on;
    logic [2:0] keypad_pwm_balance;
    logic [2:0] keypad_pwm_level;
    logic       keypad_overlap_mode;
    logic [1:0] sink1_max_scale;
    logic [1:0] sink2_max_scale;
    logic [1:0] sink3_max_scale;
    logic       fade_duration_select;
    logic       fade_on_primary;
    logic       fade_on_secondary;
    logic       primary_on;
    logic       secondary_on;
    logic [7:0] primary_code;
    logic [7:0] secondary_code;
    logic       ext_pwm_pin_enable;
    logic [2:0] gpio_direction;
    logic [2:0] gpio_levels;
    logic       active_not_standby;
    logic       boost_enable;
    logic       boost_dummy_load_enable;
    logic [7:0] boost_voltage;
  } lcrb_ctrl_t;

endpackage : lcrb_pkg

// File: hdl/lcrb_reg8.sv
// Purpose : one byte register with per-bit write mask and power-on value
// Assumes : write strobe is a single-cycle level from the register port
// Notes   : bits outside the mask never leave their power-on value
module lcrb_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] RW_MASK   = 8'hFF
) (
  input  wire logic       clock_in,   // device clock
  input  wire logic       rstn_in,    // async reset, active low
  input  wire logic       wr_in,      // write this register
  input  wire logic [7:0] wdata_in,   // write data
  output logic      [7:0] q_out       // stored value
);

  logic [7:0] q_reg;
  logic [7:0] q_next;

  // read-only bits are rebuilt from the constant, so a stray write cannot flip them
  always_comb begin
    q_next = (q_reg & RW_MASK) | (RESET_VAL & ~RW_MASK);
    if (wr_in) begin
      q_next = (wdata_in & RW_MASK) | (RESET_VAL & ~RW_MASK);
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q_reg <= RESET_VAL;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q_out = q_reg;

endmodule : lcrb_reg8

// File: bench/tb.sv
// Purpose : self-checking bench for the lighting control register bank
// Assumes : byte strobe port, read data valid on the edge after the read is taken
// Notes   : fade counts are shortened to 10 and 20 cycles to keep the run brief
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------------
  localparam int FSHORT = 10;
  localparam int FLONG  = 20;
  logic                 clock_in;
  logic                 rstn_in;
  logic                 reg_wr_in;
  logic                 reg_rd_in;
  logic [7:0]           reg_addr_in;
  logic [7:0]           reg_wdata_in;
  logic [7:0]           reg_rdata_out;
  logic                 reg_rvalid_out;
  logic                 ext_pwm_in;
  lcrb_pkg::lcrb_ctrl_t ctrl_out;
  logic [27:0]          fade_cycles_out;
  int                   error_cnt;
  int                   total_checks;
  int                   cycle_cnt = 0;

  lcrb_bank #(.FADE_SHORT_CYCLES(FSHORT), .FADE_LONG_CYCLES(FLONG)) DUT (
    .clock_in(clock_in), .rstn_in(rstn_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .ext_pwm_in(ext_pwm_in), .ctrl_out(ctrl_out), .fade_cycles_out(fade_cycles_out));

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // a hang would otherwise leave the run open forever
  always @(posedge clock_in) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 3000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [27:0] exp, input logic [27:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("rvalid", 28'(1'b1), 28'(reg_rvalid_out));
    chk($sformatf("rdata %0h", a), 28'(exp), 28'(reg_rdata_out));
  endtask : rd

  // controls follow the register by one edge
  task automatic settle();
    @(posedge clock_in);
    @(posedge clock_in);
    #1;
  endtask : settle

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic test_defaults();
    for (int i = 0; i < lcrb_pkg::NUM_REGS; i++) rd(lcrb_pkg::REG_OFS[i], lcrb_pkg::REG_RST[i]);
    rd(8'h08, 8'h00);
    rd(8'h2C, 8'h00);
    chk("ctrl reset", 28'({1'b1, 1'b1, 8'h08}), 28'({ctrl_out.keypad_drive_style,
        ctrl_out.boost_dummy_load_enable, ctrl_out.boost_voltage}));
    chk("fade reset", 28'(FSHORT), fade_cycles_out);
    $display("test defaults done");
  endtask : test_defaults

  task automatic test_access();
    for (int i = 0; i < lcrb_pkg::NUM_REGS; i++) wr(lcrb_pkg::REG_OFS[i], 8'hFF);
    wr(8'h08, 8'hFF);
    wr(8'hFF, 8'hFF);
    for (int i = 0; i < lcrb_pkg::NUM_REGS; i++) rd(lcrb_pkg::REG_OFS[i], lcrb_pkg::REG_RW[i] | (lcrb_pkg::REG_RST[i] & ~lcrb_pkg::REG_RW[i]));
    rd(8'h08, 8'h00);
    rd(8'hFF, 8'h00);
    for (int i = 0; i < lcrb_pkg::NUM_REGS; i++) wr(lcrb_pkg::REG_OFS[i], 8'h00);
    for (int i = 0; i < lcrb_pkg::NUM_REGS; i++) rd(lcrb_pkg::REG_OFS[i], lcrb_pkg::REG_RST[i] & ~lcrb_pkg::REG_RW[i]);
    $display("test access done");
  endtask : test_access

  task automatic test_keypad();
    wr(8'h00, 8'hC8);
    settle();
    chk("keypad ctl", 28'(6'b110001), 28'({ctrl_out.keypad_internal_dim_enable, ctrl_out.keypad_outputs_enable, ctrl_out.keypad_drive_style, ctrl_out.keypad_sink_on}));
    wr(8'h00, 8'h2E);
    settle();
    chk("keypad off", 28'(6'b001000), 28'({ctrl_out.keypad_internal_dim_enable, ctrl_out.keypad_outputs_enable, ctrl_out.keypad_drive_style, ctrl_out.keypad_sink_on}));
    wr(8'h01, 8'h3C);
    wr(8'h02, 8'h1B);
    settle();
    chk("keypad dim", 28'(7'b0111100), 28'({ctrl_out.keypad_pwm_balance, ctrl_out.keypad_pwm_level, ctrl_out.keypad_overlap_mode}));
    chk("sink scale", 28'(6'b011011), 28'({ctrl_out.sink1_max_scale, ctrl_out.sink2_max_scale, ctrl_out.sink3_max_scale}));
    wr(8'h01, 8'h01);
    settle();
    chk("overlap", 28'(7'b0000001), 28'({ctrl_out.keypad_pwm_balance, ctrl_out.keypad_pwm_level, ctrl_out.keypad_overlap_mode}));
    $display("test keypad done");
  endtask : test_keypad

  task automatic test_backlight();
    wr(8'h04, 8'h5A);
    rd(8'h04, 8'h5A);
    wr(8'h05, 8'h33);
    wr(8'h03, 8'h24);
    settle();
    chk("shared code", 28'(8'h5A), 28'(ctrl_out.secondary_code));
    chk("fade long", 28'(FLONG), fade_cycles_out);
    wr(8'h03, 8'h1B);
    settle();
    chk("bl ctl", 28'(4'b0111), 28'({ctrl_out.fade_on_primary, ctrl_out.fade_on_secondary, ctrl_out.primary_on, ctrl_out.secondary_on}));
    chk("own code", 28'(8'h33), 28'(ctrl_out.secondary_code));
    chk("pri code", 28'(8'h5A), 28'(ctrl_out.primary_code));
    chk("fade short", 28'(FSHORT), fade_cycles_out);
    wr(8'h03, 8'h0A);
    settle();
    chk("bl ctl2", 28'(4'b1010), 28'({ctrl_out.fade_on_primary, ctrl_out.fade_on_secondary, ctrl_out.primary_on, ctrl_out.secondary_on}));
    $display("test backlight done");
  endtask : test_backlight

  task automatic test_ext_dim();
    wr(8'h0B, 8'h64);
    wr(8'h2B, 8'h1F);
    wr(8'h00, 8'h4E);
    wr(8'h03, 8'h03);
    settle();
    chk("power", 28'(3'b111), 28'({ctrl_out.active_not_standby, ctrl_out.boost_enable, ctrl_out.boost_dummy_load_enable}));
    chk("ext low", 28'(5'b00000), 28'({ctrl_out.keypad_sink_on, ctrl_out.primary_on, ctrl_out.secondary_on}));
    @(posedge clock_in);
    ext_pwm_in <= 1'b1;
    settle();
    chk("ext high", 28'(5'b11111), 28'({ctrl_out.keypad_sink_on, ctrl_out.primary_on, ctrl_out.secondary_on}));
    wr(8'h2B, 8'h00);
    @(posedge clock_in);
    ext_pwm_in <= 1'b0;
    settle();
    chk("ext off", 28'(5'b11111), 28'({ctrl_out.keypad_sink_on, ctrl_out.primary_on, ctrl_out.secondary_on}));
    wr(8'h06, 8'h15);
    wr(8'h07, 8'h06);
    wr(8'h0D, 8'h12);
    settle();
    chk("gpio dir", 28'(4'b1101), 28'({ctrl_out.ext_pwm_pin_enable, ctrl_out.gpio_direction}));
    chk("gpio lvl", 28'(3'b110), 28'(ctrl_out.gpio_levels));
    chk("boost code", 28'(8'h12), 28'(ctrl_out.boost_voltage));
    $display("test ext_dim done");
  endtask : test_ext_dim

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rstn_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    ext_pwm_in = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    repeat (3) @(posedge clock_in);
    rstn_in <= 1'b1;
    test_defaults();
    test_access();
    test_keypad();
    test_backlight();
    test_ext_dim();
    complete_run();
  end
endmodule : tb
